// >>> core/pmw_pkg.sv
`default_nettype none
package pmw_pkg;
  localparam logic [7:0] IRQ_FLAG_OFS = 8'hc8;
  localparam logic [7:0] IRQ_EN_OFS = 8'hc9;
  localparam logic [7:0] MODE_CTRL_OFS = 8'hca;
  localparam logic [7:0] STACK_CTRL_OFS = 8'hdf;
  localparam logic [7:0] TIMER_CTRL_OFS = 8'hd8;
  localparam logic [7:0] STATUS_OFS = 8'hd9;
  localparam logic [7:0] IRQ_MASK = 8'h77;
  localparam logic [7:0] IRQ_RESET = 8'h00;
  localparam logic [2:0] STACK_RESET = 3'h7;
  localparam logic [11:0] VECTOR_ADDR = 12'h008;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SLEEP = 2'h1;
  localparam logic [1:0] MODE_GREEN = 2'h2;
  localparam int IRQ_PIN = 0;
  localparam int IRQ_TMR_A = 4;
  localparam int IRQ_USB = 6;
  localparam int HCLK_NS = 10;
  localparam int RC_SETTLE_HCLK = 4;
  localparam int XTAL_SETTLE_HCLK = 2048;
  localparam logic [11:0] RC_SETTLE_CYC = 12'(RC_SETTLE_HCLK);
  localparam logic [11:0] XTAL_SETTLE_CYC = 12'(XTAL_SETTLE_HCLK);
  localparam int RTC_PERIOD_MS = 500;
  localparam int RTC_PERIOD_CYC = RTC_PERIOD_MS * 1000000 / HCLK_NS;
  localparam int LOW_RC_DIV = 6000;
  typedef enum logic [3:0] {
    PMW_RUN = 4'h1,
    PMW_SLEEP = 4'h2,
    PMW_GREEN = 4'h4,
    PMW_SETTLE = 4'h8
  } pmw_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pmw_bus_t;
  typedef struct packed {
    logic high_osc_run;
    logic low_rc_run;
    logic sys_on_low_clk;
    logic cpu_run;
    logic timer_a_active;
    logic counter_b_active;
    logic watchdog_active;
  } pmw_gate_t;
endpackage : pmw_pkg
`default_nettype wire

// >>> core/pmw_settle.sv
`default_nettype none
module pmw_settle (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic xtal_sel,
  input wire logic osc_ready,
  output logic done
);
  import pmw_pkg::*;
  logic [11:0] cnt_reg;
  logic busy_reg;
  logic [11:0] term;
  assign term = xtal_sel ? XTAL_SETTLE_CYC : RC_SETTLE_CYC;
  // crystal count only runs once the oscillator reports start-up
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cnt_reg <= 12'h000;
      busy_reg <= 1'b0;
    end else if (start) begin
      cnt_reg <= 12'h000;
      busy_reg <= 1'b1;
    end else if (busy_reg && (osc_ready || !xtal_sel)) begin
      if (cnt_reg == term - 12'h001) begin
        busy_reg <= 1'b0;
      end
      cnt_reg <= cnt_reg + 12'h001;
    end
  end
  assign done = busy_reg && (osc_ready || !xtal_sel) && (cnt_reg == term - 12'h001);
  settle_len_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    start && !xtal_sel |-> !done [*4] ##1 done)
    else $error("rc settle not four cycles");
endmodule : pmw_settle
`default_nettype wire

// >>> core/pmw_ctrl.sv
`default_nettype none
module pmw_ctrl #(
  parameter int RTC_CYC = pmw_pkg::RTC_PERIOD_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire pmw_pkg::pmw_bus_t bus,
  output logic [7:0] rdata,
  input wire logic [7:0] port0_in,
  input wire logic [7:0] port1_in,
  input wire logic usb_toggle,
  input wire logic ext_pin_event,
  input wire logic capture_a_event,
  input wire logic capture_b_event,
  input wire logic counter_b_ovf,
  input wire logic xtal_sel,
  input wire logic osc_ready,
  input wire logic watchdog_option,
  input wire logic irq_return,
  output pmw_pkg::pmw_gate_t gate,
  output logic irq_take,
  output logic [11:0] irq_vector,
  output logic [2:0] stack_level,
  output logic timer_a_ovf
);
  import pmw_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [1:0] cpu_mode_select;
  logic slow_clock_select;
  logic high_osc_stop;
  logic timer_a_run;
  logic counter_b_run;
  logic rtc_function_enable;
  logic global_irq_enable;
  logic [2:0] stack_pointer_reg;
  logic [7:0] irq_flag_reg;
  logic [7:0] irq_en_reg;
  logic [7:0] irq_set;
  pmw_state_t state_reg;
  logic prev_slow_reg;
  logic [15:0] port_snap_reg;
  logic [7:0] tmr_a_reg;
  logic [31:0] rtc_cnt_reg;
  logic port_change;
  logic sleep_wake;
  logic green_wake;
  logic settle_start;
  logic settle_done;
  logic mode_write;
  logic [7:0] rdata_reg;

  function automatic logic hit(input pmw_bus_t b, input logic [7:0] ofs);
    hit = b.wr && (b.addr == ofs);
  endfunction : hit

  assign mode_write = hit(bus, MODE_CTRL_OFS);

  ////////////////////////////////////////////////////////////////////////
  // mode control register
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cpu_mode_select <= MODE_NORMAL;
      slow_clock_select <= 1'b0;
      high_osc_stop <= 1'b0;
    end else if (state_reg != PMW_RUN) begin
      cpu_mode_select <= MODE_NORMAL; // mode bits self-clear as soon as run is left
      if (sleep_wake) begin
        slow_clock_select <= 1'b0;
        high_osc_stop <= 1'b0;
      end
    end else if (mode_write) begin
      cpu_mode_select <= bus.wdata[4:3];
      slow_clock_select <= bus.wdata[2];
      high_osc_stop <= bus.wdata[1];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      timer_a_run <= 1'b0;
      counter_b_run <= 1'b0;
      rtc_function_enable <= 1'b0;
    end else if (hit(bus, TIMER_CTRL_OFS)) begin
      timer_a_run <= bus.wdata[0];
      counter_b_run <= bus.wdata[1];
      rtc_function_enable <= bus.wdata[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode sequencer
  assign port_change = ({port1_in, port0_in} != port_snap_reg);
  assign sleep_wake = (state_reg == PMW_SLEEP) && (port_change || usb_toggle);
  // timer a wakes green only with its irq enabled, otherwise pins and usb only
  assign green_wake = (state_reg == PMW_GREEN) && (port_change || usb_toggle
    || (timer_a_ovf && irq_en_reg[IRQ_TMR_A]));
  assign settle_start = sleep_wake;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_reg <= PMW_RUN;
    end else begin
      unique case (state_reg)
        PMW_RUN: begin
          if (cpu_mode_select == MODE_SLEEP) begin
            state_reg <= PMW_SLEEP;
          end else if (cpu_mode_select == MODE_GREEN) begin
            state_reg <= PMW_GREEN;
          end
        end
        PMW_SLEEP: begin
          if (sleep_wake) begin
            state_reg <= PMW_SETTLE;
          end
        end
        PMW_GREEN: begin
          if (green_wake) begin
            state_reg <= PMW_RUN;
          end
        end
        PMW_SETTLE: begin
          if (settle_done) begin
            state_reg <= PMW_RUN;
          end
        end
        default: state_reg <= PMW_RUN;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      port_snap_reg <= 16'h0000;
      prev_slow_reg <= 1'b0;
    end else if (state_reg == PMW_RUN) begin
      port_snap_reg <= {port1_in, port0_in};
      prev_slow_reg <= slow_clock_select;
    end
  end

  pmw_settle u_settle (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .start(settle_start),
    .xtal_sel(xtal_sel),
    .osc_ready(osc_ready),
    .done(settle_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // clock and block gating
  always_comb begin
    gate.high_osc_run = (state_reg == PMW_RUN || state_reg == PMW_GREEN) && !high_osc_stop
      || state_reg == PMW_SETTLE;
    gate.low_rc_run = (state_reg != PMW_SLEEP);
    gate.sys_on_low_clk = slow_clock_select;
    gate.cpu_run = (state_reg == PMW_RUN);
    gate.timer_a_active = timer_a_run && (state_reg == PMW_RUN || state_reg == PMW_GREEN);
    gate.counter_b_active = counter_b_run && (state_reg == PMW_RUN);
    gate.watchdog_active = watchdog_option;
  end

  ////////////////////////////////////////////////////////////////////////
  // timer a: plain 8-bit count, or 0.5 s rtc tick
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      tmr_a_reg <= 8'h00;
      rtc_cnt_reg <= 32'h0;
    end else if (gate.timer_a_active) begin
      if (rtc_function_enable) begin
        rtc_cnt_reg <= (rtc_cnt_reg == 32'(RTC_CYC - 1)) ? 32'h0 : rtc_cnt_reg + 32'h1;
      end else begin
        tmr_a_reg <= tmr_a_reg + 8'h01;
      end
    end
  end
  assign timer_a_ovf = gate.timer_a_active && (rtc_function_enable ?
    (rtc_cnt_reg == 32'(RTC_CYC - 1)) : (tmr_a_reg == 8'hff));

  ////////////////////////////////////////////////////////////////////////
  // interrupt flags and enables
  // sources are ignored in sleep except ext_pin_event, which still latches its flag but does not wake
  assign irq_set = (state_reg == PMW_SLEEP) ? {7'h00, ext_pin_event} : (
    {1'b0, usb_toggle, counter_b_ovf && gate.counter_b_active, timer_a_ovf,
     1'b0, capture_b_event, capture_a_event, ext_pin_event});

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_flag_reg <= IRQ_RESET;
    end else if (hit(bus, IRQ_FLAG_OFS)) begin
      irq_flag_reg <= (bus.wdata | irq_set) & IRQ_MASK;
    end else begin
      irq_flag_reg <= (irq_flag_reg | irq_set) & IRQ_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_en_reg <= IRQ_RESET;
    end else if (hit(bus, IRQ_EN_OFS)) begin
      irq_en_reg <= bus.wdata & IRQ_MASK;
    end
  end

  // one take per request set; entry clears enable so no re-take
  assign irq_take = global_irq_enable && gate.cpu_run
    && ((irq_flag_reg & irq_en_reg) != 8'h00);
  assign irq_vector = VECTOR_ADDR;
  assign stack_level = stack_pointer_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      global_irq_enable <= 1'b0;
      stack_pointer_reg <= STACK_RESET;
    end else if (irq_take) begin
      global_irq_enable <= 1'b0;
      stack_pointer_reg <= stack_pointer_reg - 3'h1;
    end else if (irq_return) begin
      global_irq_enable <= 1'b1;
      stack_pointer_reg <= stack_pointer_reg + 3'h1;
    end else if (hit(bus, STACK_CTRL_OFS)) begin
      global_irq_enable <= bus.wdata[7];
      stack_pointer_reg <= bus.wdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after strobe; unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rdata_reg <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        IRQ_FLAG_OFS: rdata_reg <= irq_flag_reg;
        IRQ_EN_OFS: rdata_reg <= irq_en_reg;
        MODE_CTRL_OFS: rdata_reg <= {3'h0, cpu_mode_select, slow_clock_select, high_osc_stop, 1'b0};
        STACK_CTRL_OFS: rdata_reg <= {global_irq_enable, 4'h0, stack_pointer_reg};
        TIMER_CTRL_OFS: rdata_reg <= {5'h00, rtc_function_enable, counter_b_run, timer_a_run};
        STATUS_OFS: rdata_reg <= {3'h0, prev_slow_reg, state_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end
  assign rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////
  sleep_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state_reg == PMW_SLEEP |-> !gate.cpu_run && !gate.low_rc_run && !gate.timer_a_active)
    else $error("sleep left a block running");
  cnt_b_green_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state_reg == PMW_GREEN |-> !gate.counter_b_active)
    else $error("counter b active in green");
  sleep_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    sleep_wake |=> state_reg == PMW_SETTLE)
    else $error("sleep wake did not settle");
  green_fast_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    green_wake |=> state_reg == PMW_RUN && slow_clock_select == $past(prev_slow_reg))
    else $error("green wake not immediate to last mode");
  green_pin_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state_reg == PMW_GREEN && !irq_en_reg[IRQ_TMR_A] && !port_change && !usb_toggle
    |=> state_reg == PMW_GREEN)
    else $error("green woke without trigger");
  take_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    irq_take |=> !global_irq_enable && stack_pointer_reg == $past(stack_pointer_reg) - 3'h1)
    else $error("take did not clear enable and push");
  no_gie_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !global_irq_enable |-> !irq_take)
    else $error("irq taken with global enable clear");
  flag_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state_reg == PMW_RUN && ext_pin_event |=> irq_flag_reg[IRQ_PIN])
    else $error("pin flag lost");
endmodule : pmw_ctrl
`default_nettype wire

// >>> testbench/pmw_partner.sv
`default_nettype none
module pmw_partner #(
  parameter int OSC_START = 30
) (
  input wire logic ref_clk,
  input wire logic [4:0] ev,
  input wire logic [1:0] flip,
  input wire logic hosc_run,
  output logic [7:0] port0_in,
  output logic [7:0] port1_in,
  output logic ext_pin_event,
  output logic capture_a_event,
  output logic capture_b_event,
  output logic counter_b_ovf,
  output logic usb_toggle,
  output logic osc_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  int osc_cnt = 0;
  initial begin
    port0_in = 8'hff;
    port1_in = 8'hff;
    {usb_toggle, counter_b_ovf, capture_b_event, capture_a_event, ext_pin_event} = 5'h00;
  end
  // pins idle high on pull-ups; a flip is one level change, held until flipped again
  always @(posedge ref_clk) begin
    {usb_toggle, counter_b_ovf, capture_b_event, capture_a_event, ext_pin_event} <= ev;
    port0_in[0] <= port0_in[0] ^ flip[0];
    port1_in[3] <= port1_in[3] ^ flip[1];
    osc_cnt <= hosc_run ? osc_cnt + 1 : 0;
  end
  // crystal is not ready until a start-up time after every restart
  assign osc_ready = (osc_cnt >= OSC_START);
endmodule : pmw_partner
`default_nettype wire

// >>> testbench/testbench.sv
`default_nettype none
module testbench;
  import pmw_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RTC = 20;
  localparam logic [7:0] FLAG_BIT [5] = '{8'h01, 8'h02, 8'h04, 8'h20, 8'h40};
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  pmw_bus_t bus = '0;
  logic [7:0] rdata, port0_in, port1_in;
  logic usb_toggle, ext_pin_event, capture_a_event, capture_b_event, counter_b_ovf;
  logic xtal_sel = 1'b0;
  logic watchdog_option = 1'b0;
  logic irq_return = 1'b0;
  logic osc_ready, irq_take, timer_a_ovf;
  pmw_gate_t gate;
  logic [11:0] irq_vector;
  logic [2:0] stack_level;
  logic [4:0] ev = 5'h00;
  logic [1:0] flip = 2'h0;
  int n_mismatch = 0;
  int tests_run = 0;

  always #5 ref_clk = ~ref_clk;

  pmw_ctrl #(.RTC_CYC(RTC)) uut (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
    .port0_in(port0_in), .port1_in(port1_in), .usb_toggle(usb_toggle),
    .ext_pin_event(ext_pin_event), .capture_a_event(capture_a_event),
    .capture_b_event(capture_b_event), .counter_b_ovf(counter_b_ovf), .xtal_sel(xtal_sel),
    .osc_ready(osc_ready), .watchdog_option(watchdog_option), .irq_return(irq_return),
    .gate(gate), .irq_take(irq_take), .irq_vector(irq_vector), .stack_level(stack_level),
    .timer_a_ovf(timer_a_ovf));

  pmw_partner #(.OSC_START(30)) partner (.ref_clk(ref_clk), .ev(ev), .flip(flip),
    .hosc_run(gate.high_osc_run), .port0_in(port0_in), .port1_in(port1_in),
    .ext_pin_event(ext_pin_event), .capture_a_event(capture_a_event),
    .capture_b_event(capture_b_event), .counter_b_ovf(counter_b_ovf),
    .usb_toggle(usb_toggle), .osc_ready(osc_ready));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string msg);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 chk(12'(rdata), 12'(exp), msg);
  endtask : rd

  task automatic kick(input logic [4:0] e, input logic [1:0] f);
    @(posedge ref_clk);
    ev <= e;
    flip <= f;
    @(posedge ref_clk);
    ev <= 5'h00;
    flip <= 2'h0;
  endtask : kick

  // counts cycles until execution resumes; running out of the bound ends the run
  task automatic wait_run(input int lo, input int hi, input string msg);
    int n;
    n = 0;
    while (gate.cpu_run !== 1'b1 && n <= hi) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk(12'(n >= lo && n <= hi), 12'h001, msg);
    if (n > hi) test_done();
  endtask : wait_run

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1 chk(12'(stack_level), 12'(STACK_RESET), "stack reset");
    chk(12'({gate.cpu_run, gate.watchdog_active}), 12'h002, "run after reset");
    rd(IRQ_FLAG_OFS, IRQ_RESET, "flags reset");
    rd(IRQ_EN_OFS, IRQ_RESET, "enables reset");
    rd(8'h00, 8'h00, "unmapped read");
    wr(IRQ_EN_OFS, 8'hff);
    rd(IRQ_EN_OFS, IRQ_MASK, "enable bits");
    wr(IRQ_FLAG_OFS, 8'hff);
    rd(IRQ_FLAG_OFS, IRQ_MASK, "flag write");
    wr(IRQ_FLAG_OFS, 8'h00);
    wr(IRQ_EN_OFS, 8'h00);
    // counter b overflow only flags while that counter is running
    wr(TIMER_CTRL_OFS, 8'h02);
    for (int i = 0; i < 5; i++) begin
      kick(5'(1 << i), 2'h0);
      rd(IRQ_FLAG_OFS, FLAG_BIT[i], "event flag");
      chk(12'(irq_take), 12'h000, "take without enable");
      wr(IRQ_FLAG_OFS, 8'h00);
    end
    wr(IRQ_EN_OFS, 8'h01);
    kick(5'h01, 2'h0);
    rd(IRQ_FLAG_OFS, 8'h01, "pin flag");
    chk(12'(irq_take), 12'h000, "held off by global enable");
    wr(STACK_CTRL_OFS, 8'h87);
    chk(12'(irq_take), 12'h001, "take");
    chk(irq_vector, VECTOR_ADDR, "vector");
    rd(STACK_CTRL_OFS, 8'h06, "entry clears enable");
    wr(IRQ_FLAG_OFS, 8'h00);
    @(posedge ref_clk);
    irq_return <= 1'b1;
    @(posedge ref_clk);
    irq_return <= 1'b0;
    rd(STACK_CTRL_OFS, 8'h87, "return restores");
    wr(STACK_CTRL_OFS, 8'h07);
    wr(IRQ_EN_OFS, 8'h00);
    // slow first, oscillator stop second
    wr(MODE_CTRL_OFS, 8'h04);
    chk(12'(gate.sys_on_low_clk), 12'h001, "slow select");
    wr(MODE_CTRL_OFS, 8'h06);
    chk(12'({gate.high_osc_run, gate.low_rc_run}), 12'h001, "high osc stop");
    // oscillator restarted but system stays slow, so no stabilising wait is owed yet
    wr(MODE_CTRL_OFS, 8'h04);
    wr(TIMER_CTRL_OFS, 8'h03);
    chk(12'({gate.timer_a_active, gate.counter_b_active}), 12'h003, "timers run");
    wr(MODE_CTRL_OFS, 8'h14);
    @(posedge ref_clk);
    #1 chk(12'({gate.cpu_run, gate.timer_a_active, gate.counter_b_active}), 12'h002,
      "green gating");
    kick(5'h00, 2'h1);
    wait_run(1, 3, "green wake on port");
    chk(12'(gate.sys_on_low_clk), 12'h001, "back to slow");
    wr(TIMER_CTRL_OFS, 8'h05);
    wr(MODE_CTRL_OFS, 8'h14);
    repeat (3 * RTC) @(posedge ref_clk);
    #1 chk(12'(gate.cpu_run), 12'h000, "no timer wake when disabled");
    kick(5'h10, 2'h0);
    wait_run(1, 3, "green wake on usb");
    wr(IRQ_EN_OFS, 8'h10);
    wr(MODE_CTRL_OFS, 8'h14);
    @(posedge ref_clk);
    #1 wait_run(1, RTC + 4, "rtc wake");
    @(posedge ref_clk);
    watchdog_option <= 1'b1;
    wr(MODE_CTRL_OFS, 8'h0c);
    @(posedge ref_clk);
    #1 chk(12'({gate.high_osc_run, gate.low_rc_run, gate.cpu_run, gate.timer_a_active,
      gate.counter_b_active, gate.watchdog_active}), 12'h001, "sleep gating");
    kick(5'h0a, 2'h0);
    repeat (4) @(posedge ref_clk);
    #1 chk(12'(gate.cpu_run), 12'h000, "no sleep wake on timers");
    kick(5'h00, 2'h1);
    wait_run(4, 9, "rc settle");
    chk(12'(gate.sys_on_low_clk), 12'h000, "wake to normal");
    @(posedge ref_clk);
    xtal_sel <= 1'b1;
    wr(MODE_CTRL_OFS, 8'h08);
    @(posedge ref_clk);
    kick(5'h10, 2'h0);
    wait_run(2048, 2090, "crystal settle");
    test_done();
  end

  initial begin
    #300us;
    n_mismatch++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
